// file: test_wkt_watchdog.sv
// test_wkt_watchdog: self-checking bench for the keyed-enable watchdog
`timescale 1ns/1ps
module test_wkt_watchdog;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic               clk;
    logic               rst_n;
    logic               osc;
    logic [2:0]         addr;
    logic [7:0]         wdata;
    logic               wr;
    logic               rd;
    logic [7:0]         rdata;
    logic               dev_rst;
    logic               pcsp_rst;
    logic               to_flag;
    logic               pd_flag;
    logic               irq;
    wkt_pkg::wkt_core_t core;
    int                 error_cnt = 0;
    int                 compares = 0;
    int                 cyc = 0;
    int                 edges;
    logic [7:0]         rv;
    logic               got_dev;
    logic               got_pcsp;
    int                 exp_ticks [3] = '{256, 1024, 4096};

    wkt_core_model u_core (.clk(clk), .core(core));
    wkt_watchdog u_dut (
        .CLK_SYS(clk), .RESET_N(rst_n), .LOW_SPEED_RC_OSCILLATOR_OSC(osc),
        .WATCHDOG_CLEAR_INSTRUCTION_INSTR(core.watchdog_clear_instruction), .HALT_INSTR(core.halt), .SLEEP_IDLE(core.sleep_idle),
        .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
        .DEVICE_RESET(dev_rst), .PC_SP_RESET(pcsp_rst), .TIMEOUT_FLAG(to_flag),
        .POWER_DOWN_FLAG(pd_flag), .IRQ(irq)
    );
    // ------------------------------------------------------------
    // clocks and timeout
    // ------------------------------------------------------------
    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end
    // oscillator at 8 system cycles; edges never coincide with clock edges
    initial begin
        osc = 1'h0;
        #5;
        forever #100 osc = ~osc;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk8
    task automatic chk1(input string n, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %b seen %b", n, e, g);
        end
    endtask : chk1
    task automatic chk_n(input string n, input int e, input int g);
        compares++;
        if (g != e) begin
            error_cnt++;
            $display("[FAIL] %s expected %0d seen %0d", n, e, g);
        end
    endtask : chk_n
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'h1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'h0;
    endtask : wr_reg
    task automatic rd_reg(input logic [2:0] a);
        @(posedge clk);
        rd <= 1'h1;
        addr <= a;
        @(posedge clk);
        rd <= 1'h0;
        @(negedge clk);
        rv = rdata;
    endtask : rd_reg
    // counts rising oscillator edges until a reset pulse or the limit
    task automatic wait_rst(input int limit);
        logic prev;
        int   n;
        edges = 0;
        prev = osc;
        got_dev = 1'h0;
        got_pcsp = 1'h0;
        for (n = 0; n < limit; n++) begin
            @(negedge clk);
            if (osc && !prev) edges++;
            prev = osc;
            got_dev = dev_rst;
            got_pcsp = pcsp_rst;
            if (got_dev === 1'h1 || got_pcsp === 1'h1) break;
        end
    endtask : wait_rst
    // act after the sync delay of an edge, so that edge is not counted twice
    task automatic align();
        @(posedge osc);
        repeat (4) @(posedge clk);
    endtask : align
    task automatic start_clear();
        align();
        u_core.issue(1'h1, 1'h0);
    endtask : start_clear
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd_reg(wkt_pkg::ADDR_CTRL);
        chk8("ctrl por", wkt_pkg::CTRL_POR, rv);
        rd_reg(wkt_pkg::ADDR_RCF);
        chk8("rcf por", 8'h00, rv);
        rd_reg(wkt_pkg::ADDR_STAT);
        chk8("stat por", 8'h01 << wkt_pkg::STAT_EN_BIT, rv);
        wr_reg(3'h7, 8'hFF);
        rd_reg(3'h7);
        chk8("unmapped", 8'h00, rv);
        rd_reg(wkt_pkg::ADDR_CTRL);
        chk8("ctrl kept", wkt_pkg::CTRL_POR, rv);
    endtask : t_reset
    task automatic t_overflow(input logic [2:0] sel, input int ticks);
        wr_reg(wkt_pkg::ADDR_CTRL, {wkt_pkg::KEY_ENABLE, sel});
        rd_reg(wkt_pkg::ADDR_CTRL);
        chk8("ctrl rw", {wkt_pkg::KEY_ENABLE, sel}, rv);
        start_clear();
        wait_rst(40000);
        chk_n("ticks to overflow", ticks, edges);
        chk1("full reset", 1'h1, got_dev);
        chk1("pc sp reset", 1'h0, got_pcsp);
        @(negedge clk);
        chk1("timeout flag", 1'h1, to_flag);
        chk1("reset one cycle", 1'h0, dev_rst);
    endtask : t_overflow
    task automatic t_irq();
        @(negedge clk);
        chk1("irq masked", 1'h0, irq);
        rd_reg(wkt_pkg::ADDR_IRQ_ST);
        chk8("irq status", 8'h01, rv);
        wr_reg(wkt_pkg::ADDR_IRQ_MSK, 8'h01);
        @(negedge clk);
        chk1("irq raised", 1'h1, irq);
        wr_reg(wkt_pkg::ADDR_IRQ_ST, 8'h01);
        @(negedge clk);
        chk1("irq cleared", 1'h0, irq);
    endtask : t_irq
    task automatic t_sel_change();
        wr_reg(wkt_pkg::ADDR_CTRL, {wkt_pkg::KEY_ENABLE, 3'h2});
        start_clear();
        wait_rst(2400);
        chk1("no early reset", 1'h0, got_dev);
        wr_reg(wkt_pkg::ADDR_CTRL, {wkt_pkg::KEY_ENABLE, 3'h0});
        wait_rst(40);
        chk1("new select applies", 1'h1, got_dev);
    endtask : t_sel_change
    task automatic t_periodic();
        repeat (3) begin
            start_clear();
            wait_rst(1600);
            chk1("cleared in time", 1'h0, got_dev);
        end
    endtask : t_periodic
    task automatic t_disable();
        wr_reg(wkt_pkg::ADDR_CTRL, {wkt_pkg::KEY_DISABLE, 3'h0});
        rd_reg(wkt_pkg::ADDR_STAT);
        chk1("enabled bit", 1'h0, rv[wkt_pkg::STAT_EN_BIT]);
        u_core.issue(1'h0, 1'h1);
        wait_rst(2600);
        chk1("disabled no reset", 1'h0, got_dev);
        wr_reg(wkt_pkg::ADDR_CTRL, {wkt_pkg::KEY_ENABLE, 3'h0});
        wait_rst(40000);
        chk1("enabled reset", 1'h1, got_dev);
        chk1("count held clear", 1'h1, edges >= 255 && edges <= 257);
    endtask : t_disable
    task automatic t_sleep();
        u_core.set_sleep(1'h1);
        u_core.issue(1'h0, 1'h1);
        @(negedge clk);
        chk1("halt pd", 1'h1, pd_flag);
        chk1("halt to", 1'h0, to_flag);
        wait_rst(40000);
        chk1("sleep pc sp", 1'h1, got_pcsp);
        chk1("sleep no full", 1'h0, got_dev);
        chk1("halt resumes", 1'h1, edges >= 255 && edges <= 257);
        @(negedge clk);
        chk1("sleep to", 1'h1, to_flag);
        chk1("sleep pd kept", 1'h1, pd_flag);
        chk1("pc sp one cycle", 1'h0, pcsp_rst);
        u_core.set_sleep(1'h0);
        u_core.issue(1'h1, 1'h0);
        @(negedge clk);
        chk1("clear pd", 1'h0, pd_flag);
    endtask : t_sleep
    task automatic t_key_fault();
        rd_reg(wkt_pkg::ADDR_RCF);
        chk8("rcf untouched", 8'h00, rv);
        wr_reg(wkt_pkg::ADDR_IRQ_ST, 8'h03);
        align();
        // one bit away from the enable key
        wr_reg(wkt_pkg::ADDR_CTRL, {5'h0B, 3'h0});
        wait_rst(100);
        chk1("key fault reset", 1'h1, got_dev);
        chk1("key fault delay", 1'h1, edges >= 2 && edges <= 3);
        rd_reg(wkt_pkg::ADDR_RCF);
        chk8("rcf set", 8'h01, rv);
        rd_reg(wkt_pkg::ADDR_IRQ_ST);
        chk8("irq kf", 8'h02, rv);
        rd_reg(wkt_pkg::ADDR_CTRL);
        chk8("ctrl reload", wkt_pkg::CTRL_POR, rv);
        u_core.issue(1'h1, 1'h1);
        rd_reg(wkt_pkg::ADDR_RCF);
        chk8("rcf sticky", 8'h01, rv);
        // power-on reset in mid-run clears the flag and the power-down state
        @(posedge clk);
        rst_n <= 1'h0;
        repeat (5) @(posedge clk);
        rst_n <= 1'h1;
        rd_reg(wkt_pkg::ADDR_RCF);
        chk8("rcf after reset", 8'h00, rv);
        rd_reg(wkt_pkg::ADDR_STAT);
        chk8("stat after reset", 8'h01 << wkt_pkg::STAT_EN_BIT, rv);
        wr_reg(wkt_pkg::ADDR_RCF, 8'hFF);
        rd_reg(wkt_pkg::ADDR_RCF);
        chk8("rcf upper", 8'h01, rv);
        wr_reg(wkt_pkg::ADDR_RCF, 8'h00);
        rd_reg(wkt_pkg::ADDR_RCF);
        chk8("rcf cleared", 8'h00, rv);
    endtask : t_key_fault
    task automatic report_and_stop();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'h0;
        addr = 3'h0;
        wdata = 8'h00;
        wr = 1'h0;
        rd = 1'h0;
        repeat (5) @(posedge clk);
        rst_n <= 1'h1;
        t_reset();
        for (int i = 0; i < 3; i++) begin
            t_overflow(3'(i), exp_ticks[i]);
        end
        t_irq();
        t_sel_change();
        t_periodic();
        t_disable();
        t_sleep();
        t_key_fault();
        report_and_stop();
    end
endmodule : test_wkt_watchdog

// file: wkt_core_model.sv
// wkt_core_model: processor core side, issuing clear and halt instructions
`timescale 1ns/1ps
module wkt_core_model (
    input  wire logic         clk,
    output wkt_pkg::wkt_core_t core
);
    // ------------------------------------------------------------
    // instruction issue
    // ------------------------------------------------------------
    initial begin
        core = '0;
    end
    // one-cycle pulses; both the clear instruction and the halt instruction clear the count
    task automatic issue(input logic clr, input logic hlt);
        @(posedge clk);
        core.watchdog_clear_instruction <= clr;
        core.halt    <= hlt;
        @(posedge clk);
        core.watchdog_clear_instruction <= 1'h0;
        core.halt    <= 1'h0;
    endtask : issue
    task automatic set_sleep(input logic s);
        @(posedge clk);
        core.sleep_idle <= s;
    endtask : set_sleep
endmodule : wkt_core_model

// file: wkt_pkg.sv
// wkt_pkg: constants and types shared by the watchdog files
package wkt_pkg;
    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 3;
    localparam int unsigned DATA_W = 8;
    localparam logic [2:0] ADDR_CTRL    = 3'h0;
    localparam logic [2:0] ADDR_RCF     = 3'h1;
    localparam logic [2:0] ADDR_STAT    = 3'h2;
    localparam logic [2:0] ADDR_IRQ_ST  = 3'h3;
    localparam logic [2:0] ADDR_IRQ_MSK = 3'h4;
    localparam logic [7:0] ZERO_BYTE    = 8'h00;
    // ------------------------------------------------------------
    // control fields and values
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_POR    = 8'h53;
    localparam logic [4:0] KEY_DISABLE = 5'h15;
    localparam logic [4:0] KEY_ENABLE  = 5'h0A;
    localparam int unsigned RCF_KF_BIT  = 0;
    localparam int unsigned STAT_TO_BIT = 0;
    localparam int unsigned STAT_PD_BIT = 1;
    localparam int unsigned STAT_EN_BIT = 2;
    localparam int unsigned IRQ_OVF_BIT = 0;
    localparam int unsigned IRQ_KF_BIT  = 1;
    localparam int unsigned IRQ_W       = 2;
    // ------------------------------------------------------------
    // counting
    // ------------------------------------------------------------
    localparam int unsigned CNT_W = 19;
    localparam logic [1:0] KF_DELAY_TICKS = 2'h2;
    localparam int unsigned SYNC_STAGES = 3;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [4:0] key;
        logic [2:0] sel;
    } wkt_ctrl_t;
    typedef struct packed {
        logic watchdog_clear_instruction;
        logic halt;
        logic sleep_idle;
    } wkt_core_t;
    typedef enum logic [1:0] {
        KF_IDLE = 2'h0,
        KF_ARM  = 2'h1,
        KF_LATE = 2'h3,
        KF_FIRE = 2'h2
    } wkt_kf_t;
endpackage : wkt_pkg

// file: wkt_tick_sync.sv
// wkt_tick_sync: brings the slow oscillator into the system clock, one pulse per rising edge
`timescale 1ns/1ps
module wkt_tick_sync (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic osc_in,
    output logic      tick
);
    logic [wkt_pkg::SYNC_STAGES-1:0] stage_r;
    logic                            level_r;

    // ------------------------------------------------------------
    // three-stage chain; first stage feeds only the second
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            stage_r <= '0;
        end else begin
            stage_r[0] <= osc_in;
            for (int i = 1; i < wkt_pkg::SYNC_STAGES; i++) begin
                stage_r[i] <= stage_r[i-1];
            end
        end
    end

    // a change counts only when the last two stages agree
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            level_r <= 1'b0;
            tick    <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (stage_r[1] == stage_r[2] && stage_r[2] != level_r) begin
                level_r <= stage_r[2];
                tick    <= stage_r[2];
            end
        end
    end
endmodule : wkt_tick_sync

// file: wkt_watchdog.sv
// wkt_watchdog: keyed-enable watchdog timer with flags, register port and interrupt
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/1ps
module wkt_watchdog (
    input  wire logic        CLK_SYS,
    input  wire logic        RESET_N,
    input  wire logic        LOW_SPEED_RC_OSCILLATOR_OSC,
    input  wire logic        WATCHDOG_CLEAR_INSTRUCTION_INSTR,
    input  wire logic        HALT_INSTR,
    input  wire logic        SLEEP_IDLE,
    input  wire logic [2:0]  REG_ADDR,
    input  wire logic [7:0]  REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic      [7:0]  REG_RDATA,
    output logic             DEVICE_RESET,
    output logic             PC_SP_RESET,
    output logic             TIMEOUT_FLAG,
    output logic             POWER_DOWN_FLAG,
    output logic             IRQ
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    wkt_pkg::wkt_ctrl_t           ctrl_r;
    wkt_pkg::wkt_core_t           core;
    wkt_pkg::wkt_kf_t             kf_state_r;
    logic [wkt_pkg::CNT_W-1:0]    cnt_r;
    logic [1:0]                   kf_ticks_r;
    logic                         kf_flag_r;
    logic                         to_r;
    logic                         pd_r;
    logic [wkt_pkg::IRQ_W-1:0]    irq_st_r;
    logic [wkt_pkg::IRQ_W-1:0]    irq_msk_r;
    logic                         tick;
    logic                         enabled;
    logic                         key_bad;
    logic                         ovf;
    logic                         kf_fire;
    logic                         clr_cnt;
    logic                         wr_ctrl;
    logic                         wr_rcf;
    logic                         wr_ist;
    logic                         wr_msk;

    // ------------------------------------------------------------
    // decoding
    // ------------------------------------------------------------
    // last count value before overflow for a select code
    function automatic logic [wkt_pkg::CNT_W-1:0] period_last(input logic [2:0] sel);
        logic [wkt_pkg::CNT_W-1:0] one;
        one = {{(wkt_pkg::CNT_W-1){1'b0}}, 1'b1};
        unique case (sel)
            3'h0: period_last = (one << 8) - one;
            3'h1: period_last = (one << 10) - one;
            3'h2: period_last = (one << 12) - one;
            3'h3: period_last = (one << 14) - one;
            3'h4: period_last = (one << 15) - one;
            3'h5: period_last = (one << 16) - one;
            3'h6: period_last = (one << 17) - one;
            3'h7: period_last = (one << 18) - one;
        endcase
    endfunction : period_last

    function automatic logic hit(input logic [2:0] addr, input logic [2:0] tgt);
        hit = (addr == tgt);
    endfunction : hit

    assign core    = '{watchdog_clear_instruction: WATCHDOG_CLEAR_INSTRUCTION_INSTR, halt: HALT_INSTR, sleep_idle: SLEEP_IDLE};
    assign wr_ctrl = REG_WR && hit(REG_ADDR, wkt_pkg::ADDR_CTRL);
    assign wr_rcf  = REG_WR && hit(REG_ADDR, wkt_pkg::ADDR_RCF);
    assign wr_ist  = REG_WR && hit(REG_ADDR, wkt_pkg::ADDR_IRQ_ST);
    assign wr_msk  = REG_WR && hit(REG_ADDR, wkt_pkg::ADDR_IRQ_MSK);

    assign enabled = (ctrl_r.key == wkt_pkg::KEY_ENABLE);
    assign key_bad = !enabled && (ctrl_r.key != wkt_pkg::KEY_DISABLE);
    assign kf_fire = (kf_state_r == wkt_pkg::KF_FIRE);
    // >= so that shrinking the period mid-count still overflows at the next oscillator edge
    assign ovf     = tick && enabled && (cnt_r >= period_last(ctrl_r.sel));
    assign clr_cnt = core.watchdog_clear_instruction || core.halt || kf_fire;

    // ------------------------------------------------------------
    // oscillator edge detection
    // ------------------------------------------------------------
    wkt_tick_sync u_tick (
        .clk     (CLK_SYS),
        .reset_n (RESET_N),
        .osc_in  (LOW_SPEED_RC_OSCILLATOR_OSC),
        .tick    (tick)
    );

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            ctrl_r <= wkt_pkg::CTRL_POR;
        end else if (kf_fire) begin
            // the fault reset is a device reset, so control returns to its power-up value
            ctrl_r <= wkt_pkg::CTRL_POR;
        end else if (wr_ctrl) begin
            ctrl_r <= REG_WDATA;
        end
    end

    // ------------------------------------------------------------
    // watchdog counter
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            cnt_r <= '0;
        end else if (clr_cnt || ovf) begin
            cnt_r <= '0;
        end else if (tick && enabled) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // key fault sequencer
    // ------------------------------------------------------------
    // once armed the reset goes ahead even if the key is repaired meanwhile
    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            kf_state_r <= wkt_pkg::KF_IDLE;
            kf_ticks_r <= '0;
        end else begin
            unique case (kf_state_r)
                wkt_pkg::KF_IDLE: begin
                    kf_ticks_r <= '0;
                    if (key_bad) begin
                        kf_state_r <= wkt_pkg::KF_ARM;
                    end
                end
                wkt_pkg::KF_ARM: begin
                    if (tick) begin
                        kf_ticks_r <= kf_ticks_r + 1'b1;
                        kf_state_r <= wkt_pkg::KF_LATE;
                    end
                end
                wkt_pkg::KF_LATE: begin
                    if (tick) begin
                        kf_ticks_r <= kf_ticks_r + 1'b1;
                        kf_state_r <= wkt_pkg::KF_FIRE;
                    end
                end
                wkt_pkg::KF_FIRE: begin
                    kf_state_r <= wkt_pkg::KF_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // reset outputs
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            DEVICE_RESET <= 1'b0;
            PC_SP_RESET  <= 1'b0;
        end else begin
            DEVICE_RESET <= kf_fire || (ovf && !core.sleep_idle);
            PC_SP_RESET  <= ovf && core.sleep_idle;
        end
    end

    // ------------------------------------------------------------
    // flags
    // ------------------------------------------------------------
    // set wins over a software write in the same cycle
    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            kf_flag_r <= 1'b0;
        end else if (kf_fire) begin
            kf_flag_r <= 1'b1;
        end else if (wr_rcf) begin
            kf_flag_r <= REG_WDATA[wkt_pkg::RCF_KF_BIT];
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            to_r <= 1'b0;
        end else if (ovf) begin
            to_r <= 1'b1;
        end else if (core.halt) begin
            to_r <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            pd_r <= 1'b0;
        end else if (core.halt) begin
            pd_r <= 1'b1;
        end else if (core.watchdog_clear_instruction) begin
            pd_r <= 1'b0;
        end
    end

    assign TIMEOUT_FLAG    = to_r;
    assign POWER_DOWN_FLAG = pd_r;

    // ------------------------------------------------------------
    // interrupt
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            irq_st_r  <= '0;
            irq_msk_r <= '0;
        end else begin
            irq_st_r <= (irq_st_r & ~(wr_ist ? REG_WDATA[wkt_pkg::IRQ_W-1:0] : '0))
                        | {kf_fire, ovf};
            if (wr_msk) begin
                irq_msk_r <= REG_WDATA[wkt_pkg::IRQ_W-1:0];
            end
        end
    end

    assign IRQ = |(irq_st_r & irq_msk_r);

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            REG_RDATA <= wkt_pkg::ZERO_BYTE;
        end else begin
            REG_RDATA <= wkt_pkg::ZERO_BYTE;
            if (REG_RD) begin
                unique case (REG_ADDR)
                    wkt_pkg::ADDR_CTRL:    REG_RDATA <= ctrl_r;
                    wkt_pkg::ADDR_RCF:     REG_RDATA <= {7'h00, kf_flag_r};
                    wkt_pkg::ADDR_STAT:    REG_RDATA <= {5'h00, enabled, pd_r, to_r};
                    wkt_pkg::ADDR_IRQ_ST:  REG_RDATA <= {6'h00, irq_st_r};
                    wkt_pkg::ADDR_IRQ_MSK: REG_RDATA <= {6'h00, irq_msk_r};
                    default:               REG_RDATA <= wkt_pkg::ZERO_BYTE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESET_N);

    a_count_tick_only: assert property (
        !tick && !clr_cnt |=> $stable(cnt_r))
        else $error("count moved without an oscillator edge");
    a_period_reach: assert property (
        ovf |-> cnt_r >= period_last(ctrl_r.sel))
        else $error("overflow before the selected period");
    a_disabled_quiet: assert property (
        ctrl_r.key == wkt_pkg::KEY_DISABLE |-> !ovf && !kf_fire)
        else $error("disabled watchdog acted");
    a_fault_arms: assert property (
        kf_state_r == wkt_pkg::KF_IDLE && key_bad |=> kf_state_r == wkt_pkg::KF_ARM)
        else $error("bad key did not arm the fault reset");
    a_fault_ticks: assert property (
        kf_fire |-> kf_ticks_r == wkt_pkg::KF_DELAY_TICKS ##1 DEVICE_RESET)
        else $error("fault reset not after two oscillator edges");
    a_fault_flag: assert property (
        kf_fire |=> kf_flag_r && ctrl_r == wkt_pkg::CTRL_POR && cnt_r == '0)
        else $error("fault reset did not set flag and reload");
    a_flag_hold: assert property (
        !kf_fire && !wr_rcf |=> $stable(kf_flag_r))
        else $error("fault flag changed without cause");
    a_por_ctrl: assert property (
        !$past(RESET_N) |-> ctrl_r == wkt_pkg::CTRL_POR)
        else $error("control not at power-up value");
    a_run_reset: assert property (
        ovf && !core.sleep_idle |=> DEVICE_RESET && to_r && !PC_SP_RESET)
        else $error("run overflow did not reset device");
    a_sleep_wake: assert property (
        ovf && core.sleep_idle |=> PC_SP_RESET && to_r && !DEVICE_RESET)
        else $error("sleep overflow wrong reset");
    a_clear_count: assert property (
        clr_cnt |=> cnt_r == '0)
        else $error("count not cleared");
    a_upper_zero: assert property (
        REG_RD && REG_ADDR == wkt_pkg::ADDR_RCF |=> REG_RDATA[7:1] == 7'h00)
        else $error("reset-cause upper bits not zero");
    a_ctrl_write: assert property (
        wr_ctrl && !kf_fire |=> ctrl_r == $past(REG_WDATA))
        else $error("control write lost");
    a_halt_stop: assert property (
        core.halt && ctrl_r.key == wkt_pkg::KEY_DISABLE && !wr_ctrl
        |=> cnt_r == '0 ##1 cnt_r == '0)
        else $error("disabled count restarted after halt");
    a_halt_flags: assert property (
        core.halt && !ovf |=> pd_r && !to_r)
        else $error("halt flags wrong");
    a_clr_pd: assert property (
        core.watchdog_clear_instruction && !core.halt |=> !pd_r)
        else $error("clear did not drop power-down");
    a_restart_zero: assert property (
        ovf |=> cnt_r == '0)
        else $error("count not restarted after overflow");

    c_run_reset:   cover property (ovf && !core.sleep_idle);
    c_sleep_wake:  cover property (ovf && core.sleep_idle);
    c_key_fault:   cover property (kf_fire);
    c_irq_raised:  cover property (IRQ);
endmodule : wkt_watchdog
